// File: hw/epw_counter_top.sv
// Four-channel edge counter and pulse-width timer with sample stream
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four identical counters, 32-bit count each
// - Eight selectable inputs per counter
// - Each counter owns a sample FIFO
// - Inner counter advanced only by source edges
// - Sample clock always comes from an input
// - Modes offer only the supported timings
// - Count source edges of chosen polarity
// - Reading count never disturbs counting
// - Active pause ignores source edges in the edge-count modes
// - Pause from gate, high or low selectable
// - Buffered count pushed each sample edge
// - Sample edge polarity is selectable
// - Counting starts at the arm event
// - Direction up, down, or external input
// - Width counts source edges during active gate
// - Partial pulse at arm is skipped
// - Single width stores once then stops
// - Implicit mode stores every trailing edge
// - Sample edge stores last completed width
// - No completed pulse between samples: overrun
// - Buffered samples stream toward host memory
module epw_counter_top #(
    parameter int DEPTH = epw_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Counter input terminals, eight per counter
    input wire logic [epw_pkg::NCTR*epw_pkg::NIN-1:0] ctr_in,
    // Sample stream toward host memory
    output logic [epw_pkg::CW-1:0] st_data,
    output logic [epw_pkg::CH_W-1:0] st_channel,
    output logic st_valid,
    input wire logic st_ready
);
    import epw_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic armed;
        logic [CW-1:0] count;
        logic [CW-1:0] inner;
        epw_pw_t pw;
        logic fresh;
        logic samp_seen;
        logic overrun;
        logic overflow;
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] prev;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] wr_vis;
        logic [PW-1:0] rd_ptr;
    } epw_chan_t;

    typedef struct packed {
        epw_chan_t [NCTR-1:0] ch;
        logic ack;
        logic [31:0] rdata;
        logic [CW-1:0] st_data;
        logic [CH_W-1:0] st_chan;
        logic st_valid;
    } epw_state_t;

    epw_state_t s_q;
    epw_state_t s_d;
    logic [NCTR-1:0] push_c, src_e_c, samp_e_c, pause_c, gact_c, gnew_c;
    logic [NCTR-1:0] arm_c, up_c, trail_c, full_c;
    logic [NCTR-1:0][CW-1:0] pdata_c;
    logic [NCTR-1:0][CW-1:0] rdata_c;
    logic [NCTR-1:0][AW-1:0] waddr_c;
    logic [NCTR-1:0][AW-1:0] raddr_c;

    // Level of one of the eight synchronised inputs
    function automatic logic pick(input logic [NIN-1:0] v, input logic [2:0] sel);
        pick = v[sel];
    endfunction : pick

    // Edge of the chosen polarity between last two samples
    function automatic logic edge_of(input logic [NIN-1:0] cur, input logic [NIN-1:0] old,
                                     input logic [2:0] sel, input logic fall);
        edge_of = fall ? (old[sel] & ~cur[sel]) : (cur[sel] & ~old[sel]);
    endfunction : edge_of

    // Mode field of a control word
    function automatic epw_mode_t mode_of(input logic [CTRL_W-1:0] ctrl);
        mode_of = epw_mode_t'(ctrl[CF_MODE +: 3]);
    endfunction : mode_of

    // Status word of one counter
    function automatic logic [31:0] status_of(input epw_chan_t c);
        status_of = (32'(c.wr_ptr - c.rd_ptr) << SF_LEVEL)
                  | (32'(c.overrun) << SF_OVERRUN)
                  | (32'(c.overflow) << SF_OVERFLOW)
                  | (32'(c.pw == PW_DONE) << SF_DONE)
                  | (32'(c.armed) << SF_ARMED);
    endfunction : status_of

    // Next state of bus slave, all counters and the stream stage
    always_comb begin
        epw_chan_t c;
        epw_chan_t n;
        epw_chan_t rsel;
        epw_mode_t m;
        logic wr_hit;
        logic clr_ovr;
        logic clr_ofl;
        logic set_ovr;
        logic push;
        logic comp;
        logic found;
        c = '0;
        n = '0;
        rsel = '0;
        m = EPW_IDLE;
        wr_hit = 1'b0;
        clr_ovr = 1'b0;
        clr_ofl = 1'b0;
        set_ovr = 1'b0;
        push = 1'b0;
        comp = 1'b0;
        found = 1'b0;
        s_d = s_q;
        push_c = '0;
        pdata_c = '0;
        waddr_c = '0;
        src_e_c = '0;
        samp_e_c = '0;
        pause_c = '0;
        gact_c = '0;
        gnew_c = '0;
        arm_c = '0;
        up_c = '0;
        trail_c = '0;
        full_c = '0;

        // One wait state: request seen, then answered on the next edge
        s_d.ack = (avs_read | avs_write) & ~s_q.ack;
        rsel = s_q.ch[avs_address[3:2]];
        if (avs_read && !s_q.ack) begin
            unique case (avs_address[1:0])
                REG_CTRL: s_d.rdata = 32'(rsel.ctrl);
                REG_COUNT: s_d.rdata = rsel.count;
                REG_STATUS: s_d.rdata = status_of(rsel);
                REG_RSVD: s_d.rdata = 32'h0;
            endcase
        end

        for (int i = 0; i < NCTR; i++) begin
            c = s_q.ch[i];
            n = c;
            push = 1'b0;
            comp = 1'b0;
            set_ovr = 1'b0;
            m = mode_of(c.ctrl);
            n.sync1 = ctr_in[i*NIN +: NIN];
            n.sync2 = c.sync1;
            n.prev = c.sync2;
            src_e_c[i] = edge_of(c.sync2, c.prev, c.ctrl[CF_SRC_SEL +: 3], c.ctrl[CF_SRC_FALL]);
            samp_e_c[i] = edge_of(c.sync2, c.prev, c.ctrl[CF_SAMP_SEL +: 3],
                                  c.ctrl[CF_SAMP_FALL]);
            gact_c[i] = pick(c.sync2, c.ctrl[CF_GATE_SEL +: 3]) ^ c.ctrl[CF_GATE_LOW];
            gnew_c[i] = pick(c.sync2, avs_writedata[CF_GATE_SEL +: 3])
                      ^ avs_writedata[CF_GATE_LOW];
            pause_c[i] = c.ctrl[CF_PAUSE_EN]
                       & (pick(c.sync2, c.ctrl[CF_GATE_SEL +: 3]) ^ c.ctrl[CF_PAUSE_LOW]);
            unique case (epw_dir_t'(c.ctrl[CF_DIR +: 2]))
                DIR_UP: up_c[i] = 1'b1;
                DIR_DOWN: up_c[i] = 1'b0;
                DIR_EXT: up_c[i] = pick(c.sync2, c.ctrl[CF_DIR_SEL +: 3]);
                default: up_c[i] = 1'b1;
            endcase
            full_c[i] = (c.wr_ptr[AW] != c.rd_ptr[AW])
                      && (c.wr_ptr[AW-1:0] == c.rd_ptr[AW-1:0]);
            trail_c[i] = c.armed && (c.pw == PW_MEAS) && !gact_c[i];
            wr_hit = avs_write && s_q.ack && (avs_address[3:2] == CH_W'(i));
            arm_c[i] = wr_hit && (avs_address[1:0] == REG_CTRL);
            clr_ovr = wr_hit && (avs_address[1:0] == REG_STATUS) && avs_writedata[SF_OVERRUN];
            clr_ofl = wr_hit && (avs_address[1:0] == REG_STATUS) && avs_writedata[SF_OVERFLOW];
            pdata_c[i] = c.count;

            if (arm_c[i]) begin
                n.ctrl = avs_writedata[CTRL_W-1:0];
                n.armed = mode_of(avs_writedata[CTRL_W-1:0]) != EPW_IDLE;
                n.count = COUNT_RST;
                n.inner = COUNT_RST;
                n.fresh = 1'b0;
                n.samp_seen = 1'b0;
                n.pw = gnew_c[i] ? PW_WAIT_IDLE : PW_WAIT_ACT;
            end else if (c.armed) begin
                unique case (m)
                    EPW_EDGE, EPW_BUF_EDGE: begin
                        if (src_e_c[i] && !pause_c[i]) begin
                            n.count = up_c[i] ? c.count + 32'h1 : c.count - 32'h1;
                        end
                        if (m == EPW_BUF_EDGE && samp_e_c[i]) begin
                            push = 1'b1;
                        end
                    end
                    EPW_PW_SINGLE, EPW_PW_IMPL, EPW_PW_SAMP: begin
                        // Inner counter holds pulse in progress
                        unique case (c.pw)
                            PW_WAIT_IDLE: begin
                                if (!gact_c[i]) begin
                                    n.pw = PW_WAIT_ACT;
                                end
                            end
                            PW_WAIT_ACT: begin
                                if (gact_c[i]) begin
                                    n.pw = PW_MEAS;
                                    n.inner = COUNT_RST;
                                end
                            end
                            PW_MEAS: begin
                                if (!gact_c[i]) begin
                                    comp = 1'b1;
                                    n.count = c.inner;
                                    n.pw = (m == EPW_PW_SINGLE) ? PW_DONE : PW_WAIT_ACT;
                                end else if (src_e_c[i]) begin
                                    n.inner = c.inner + 32'h1;
                                end
                            end
                            PW_DONE: n.pw = PW_DONE;
                        endcase
                        if (comp && m != EPW_PW_SAMP) begin
                            push = 1'b1;
                            pdata_c[i] = c.inner;
                        end
                        if (m == EPW_PW_SAMP) begin
                            n.fresh = c.fresh | comp;
                            // Sample clock from an input only
                            if (samp_e_c[i]) begin
                                n.samp_seen = 1'b1;
                                if (comp || c.fresh) begin
                                    push = 1'b1;
                                    pdata_c[i] = comp ? c.inner : c.count;
                                    n.fresh = 1'b0;
                                end else if (c.samp_seen) begin
                                    set_ovr = 1'b1;
                                end
                            end
                        end
                    end
                    default: n.armed = 1'b0;
                endcase
            end

            // FIFO write; a full FIFO drops and flags
            push_c[i] = push && !full_c[i];
            waddr_c[i] = c.wr_ptr[AW-1:0];
            if (push_c[i]) begin
                n.wr_ptr = c.wr_ptr + PW'(1);
            end
            // Reader sees an entry one cycle late, after the memory holds it
            n.wr_vis = c.wr_ptr;
            // Hardware set wins over a software clear in the same cycle
            n.overrun = (c.overrun && !clr_ovr) || set_ovr;
            n.overflow = (c.overflow && !clr_ofl) || (push && full_c[i]);
            s_d.ch[i] = n;
        end

        // Lowest non-empty channel feeds the stream
        if (!s_q.st_valid || st_ready) begin
            s_d.st_valid = 1'b0;
            for (int i = 0; i < NCTR; i++) begin
                if (!found && (s_q.ch[i].rd_ptr != s_q.ch[i].wr_vis)) begin
                    found = 1'b1;
                    s_d.st_valid = 1'b1;
                    s_d.st_data = rdata_c[i];
                    s_d.st_chan = CH_W'(i);
                    s_d.ch[i].rd_ptr = s_q.ch[i].rd_ptr + PW'(1);
                end
            end
        end
    end

    // All state but the sample memories in one register; clock enable freezes everything
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Wait request combinational; stream valid and all data from flops
    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign st_data = s_q.st_data;
    assign st_channel = s_q.st_chan;
    assign st_valid = s_q.st_valid;

    default clocking cb_main @(posedge clk iff ce);
    endclocking
    default disable iff (!nrst);

    genvar g;
    generate
        for (g = 0; g < NCTR; g++) begin : g_ch
            epw_mode_t mode_g;
            logic run_g;
            assign mode_g = mode_of(s_q.ch[g].ctrl);
            assign run_g = s_q.ch[g].armed && !arm_c[g];
            // Memory reads the pointer it will hold after this edge
            assign raddr_c[g] = s_d.ch[g].rd_ptr[AW-1:0];

            epw_fifo_mem #(
                .WIDTH(CW),
                .DEPTH(DEPTH)
            ) u_mem (
                .clk(clk),
                .nrst(nrst),
                .ce(ce),
                .we(push_c[g]),
                .waddr(waddr_c[g]),
                .wdata(pdata_c[g]),
                .raddr(raddr_c[g]),
                .rdata(rdata_c[g])
            );

            sequence s_done_hold;
                (s_q.ch[g].pw == PW_DONE && $stable(s_q.ch[g].count)) [*2];
            endsequence
            sequence s_edge_ok;
                run_g && mode_g == EPW_EDGE && src_e_c[g] && !pause_c[g];
            endsequence

            property p_pause_hold;
                run_g && mode_g == EPW_EDGE && src_e_c[g] && pause_c[g]
                    |=> $stable(s_q.ch[g].count);
            endproperty
            a_pause_hold: assert property (p_pause_hold)
                else $error("count moved while paused");

            property p_count_up;
                s_edge_ok and up_c[g] |=> s_q.ch[g].count == $past(s_q.ch[g].count) + 32'h1;
            endproperty
            a_count_up: assert property (p_count_up)
                else $error("up count did not advance by one");

            property p_wrap;
                s_edge_ok and !up_c[g] && s_q.ch[g].count == COUNT_RST
                    |=> s_q.ch[g].count == COUNT_MAX;
            endproperty
            a_wrap: assert property (p_wrap)
                else $error("down count did not wrap");

            property p_read_keep;
                run_g && mode_g == EPW_EDGE && !src_e_c[g] && avs_read
                    |=> $stable(s_q.ch[g].count);
            endproperty
            a_read_keep: assert property (p_read_keep)
                else $error("read disturbed count");

            property p_arm_clear;
                arm_c[g] |=> s_q.ch[g].count == COUNT_RST && s_q.ch[g].inner == COUNT_RST;
            endproperty
            a_arm_clear: assert property (p_arm_clear)
                else $error("arm did not clear count");

            property p_partial;
                arm_c[g] && gnew_c[g] |=> s_q.ch[g].pw == PW_WAIT_IDLE;
            endproperty
            a_partial: assert property (p_partial)
                else $error("partial pulse measured");

            property p_buf_push;
                run_g && mode_g == EPW_BUF_EDGE && samp_e_c[g] && !full_c[g]
                    |=> s_q.ch[g].wr_ptr == $past(s_q.ch[g].wr_ptr) + PW'(1);
            endproperty
            a_buf_push: assert property (p_buf_push)
                else $error("sample edge did not store count");

            // Count takes the width at the trailing edge, so hold is judged from the cycle after
            property p_single;
                run_g && mode_g == EPW_PW_SINGLE && trail_c[g]
                    |=> s_q.ch[g].pw == PW_DONE ##1 s_done_hold;
            endproperty
            a_single: assert property (p_single)
                else $error("single width not held");

            property p_impl;
                run_g && mode_g == EPW_PW_IMPL && trail_c[g] && !full_c[g]
                    |=> s_q.ch[g].count == $past(s_q.ch[g].inner)
                        && s_q.ch[g].wr_ptr == $past(s_q.ch[g].wr_ptr) + PW'(1);
            endproperty
            a_impl: assert property (p_impl)
                else $error("trailing edge width not stored");

            property p_overrun;
                run_g && mode_g == EPW_PW_SAMP && samp_e_c[g] && !trail_c[g]
                    && !s_q.ch[g].fresh && s_q.ch[g].samp_seen |=> s_q.ch[g].overrun;
            endproperty
            a_overrun: assert property (p_overrun)
                else $error("overrun not flagged");
        end
    endgenerate
endmodule : epw_counter_top
`default_nettype wire

// File: hw/epw_pkg.sv
// Constants and types shared by the edge and pulse-width counter block
package epw_pkg;
    // Block shape
    localparam int NCTR = 4;
    localparam int NIN = 8;
    localparam int CW = 32;
    localparam int CH_W = 2;
    localparam int FIFO_DEPTH = 16;
    // Word offsets inside one counter's group of four registers
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_RSVD = 2'h3;
    // Control word field positions
    localparam int CF_MODE = 0;
    localparam int CF_SRC_FALL = 3;
    localparam int CF_PAUSE_EN = 4;
    localparam int CF_PAUSE_LOW = 5;
    localparam int CF_GATE_LOW = 6;
    localparam int CF_SAMP_FALL = 7;
    localparam int CF_DIR = 8;
    localparam int CF_SRC_SEL = 10;
    localparam int CF_GATE_SEL = 13;
    localparam int CF_DIR_SEL = 16;
    localparam int CF_SAMP_SEL = 19;
    localparam int CTRL_W = 22;
    // Status word field positions
    localparam int SF_OVERRUN = 0;
    localparam int SF_OVERFLOW = 1;
    localparam int SF_DONE = 2;
    localparam int SF_ARMED = 3;
    localparam int SF_LEVEL = 8;
    // Values after reset and count limits
    localparam logic [CTRL_W-1:0] CTRL_RST = 22'h0;
    localparam logic [CW-1:0] COUNT_RST = 32'h0;
    localparam logic [CW-1:0] COUNT_MAX = 32'hffffffff;
    // Measurement modes
    typedef enum logic [2:0] {
        EPW_IDLE = 3'h0,
        EPW_EDGE = 3'h1,
        EPW_BUF_EDGE = 3'h2,
        EPW_PW_SINGLE = 3'h3,
        EPW_PW_IMPL = 3'h4,
        EPW_PW_SAMP = 3'h5
    } epw_mode_t;
    // Count direction
    typedef enum logic [1:0] {
        DIR_UP = 2'h0,
        DIR_DOWN = 2'h1,
        DIR_EXT = 2'h2
    } epw_dir_t;
    // Pulse-width sequencer, Gray coded
    typedef enum logic [1:0] {
        PW_WAIT_IDLE = 2'b00,
        PW_WAIT_ACT = 2'b01,
        PW_MEAS = 2'b11,
        PW_DONE = 2'b10
    } epw_pw_t;
endpackage : epw_pkg

// File: hw/epw_fifo_mem.sv
// Sample memory of one counter with registered read data
`timescale 1ns/1ps
`default_nettype none
module epw_fifo_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // Storage has no reset so it maps onto block memory
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read is one cycle late; same-address write returns old data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= mem[raddr];
        end
    end

    assign rdata = rdata_q;
endmodule : epw_fifo_mem
`default_nettype wire

// File: tb/epw_sig_model.sv
// Stand-in for the external source, gate, direction and sample clock pins
`timescale 1ns/1ps
`default_nettype none
module epw_sig_model (
    // Clock
    input wire logic clk,
    // Pins of one counter: 0 source, 1 gate, 2 sample clock, 3 direction
    output logic [7:0] pins
);
    initial pins = 8'h00;
    // sample clock from pin
    // Levels last four cycles so the two-flop synchroniser never misses one
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            @(posedge clk) pins[b] <= 1'b1;
            repeat (4) @(posedge clk);
            pins[b] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulse
    task automatic level(input int b, input logic v);
        @(posedge clk) pins[b] <= v;
        repeat (5) @(posedge clk);
    endtask : level
    task automatic gated(input int n);
        level(1, 1'b1);
        pulse(0, n);
        level(1, 1'b0);
    endtask : gated
endmodule : epw_sig_model
`default_nettype wire

// File: tb/epw_counter_top_tb_top.sv
// Self-checking bench for the four-channel edge and pulse-width counter
`timescale 1ns/1ps
`default_nettype none
module epw_counter_top_tb_top;
    import epw_pkg::*;
    logic clk, nrst, ce, avs_read, avs_write, avs_waitrequest, st_valid, st_ready;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, st_data;
    logic [1:0] st_channel;
    logic [7:0] pins;
    logic [23:0] other_pins;
    logic [31:0] rd_q[$], st_q[$];
    int failures, checks_done, n;
    epw_counter_top #(.DEPTH(16)) dut_u (.clk(clk), .nrst(nrst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ctr_in({other_pins, pins}), .st_data(st_data),
        .st_channel(st_channel), .st_valid(st_valid), .st_ready(st_ready));
    epw_sig_model model_u (.clk(clk), .pins(pins));
    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // Request stands until waitrequest is sampled low at a rising edge, then drops there
    task automatic bus(input logic w, input logic [1:0] r, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        avs_address <= {2'h0, r};
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 100);
        // A slave that never answers counts as a mismatch
        if (avs_waitrequest !== 1'b0) begin
            failures++;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rd(input logic [1:0] r, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, r, 32'h0);
    endtask : rd
    // Compare each answer with the oldest note; the sink stalls at random
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check(avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hx, "read");
        end
        if (st_valid === 1'b1 && st_ready === 1'b1) begin
            check({30'h0, st_channel}, 32'h0, "channel");
            check(st_data, st_q.size() ? st_q.pop_front() : 32'hx, "stream");
        end
        st_ready <= 1'($urandom_range(0, 1));
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        void'($urandom(32'hcf8b));
        other_pins = 24'($urandom());
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // Edge count on rising then falling source, read in mid-run
        for (int f = 0; f < 2; f++) begin
            n = $urandom_range(3, 8);
            bus(1'b1, REG_CTRL, 32'(EPW_EDGE) | (32'(f) << CF_SRC_FALL));
            model_u.pulse(0, n);
            rd(REG_COUNT, 32'(n));
            model_u.pulse(0, 2);
            rd(REG_COUNT, 32'(n + 2));
        end
        // Pause while gate high
        bus(1'b1, REG_CTRL, 32'(EPW_EDGE) | (32'h1 << CF_PAUSE_EN) | (32'h1 << CF_GATE_SEL));
        model_u.level(1, 1'b1);
        model_u.pulse(0, 3);
        model_u.level(1, 1'b0);
        model_u.pulse(0, 2);
        rd(REG_COUNT, 32'h2);
        // Pause while gate low: only the edge inside the high gate counts
        bus(1'b1, REG_CTRL, 32'(EPW_EDGE) | (32'h1 << CF_PAUSE_EN) | (32'h1 << CF_PAUSE_LOW)
            | (32'h1 << CF_GATE_SEL));
        model_u.pulse(0, 2);
        model_u.level(1, 1'b1);
        model_u.pulse(0, 1);
        model_u.level(1, 1'b0);
        rd(REG_COUNT, 32'h1);
        // Down count wraps, then external direction
        bus(1'b1, REG_CTRL, 32'(EPW_EDGE) | (32'(DIR_DOWN) << CF_DIR));
        model_u.pulse(0, 3);
        rd(REG_COUNT, 32'hfffffffd);
        bus(1'b1, REG_CTRL, 32'(EPW_EDGE) | (32'(DIR_EXT) << CF_DIR) | (32'h3 << CF_DIR_SEL));
        model_u.level(3, 1'b1);
        model_u.pulse(0, 3);
        model_u.level(3, 1'b0);
        model_u.pulse(0, 1);
        rd(REG_COUNT, 32'h2);
        // Buffered edge count, counting from arm, cumulative samples
        n = $urandom_range(2, 6);
        bus(1'b1, REG_CTRL, 32'(EPW_BUF_EDGE) | (32'h2 << CF_SAMP_SEL));
        model_u.pulse(0, n);
        st_q.push_back(32'(n));
        model_u.pulse(2, 1);
        model_u.pulse(0, 1);
        st_q.push_back(32'(n + 1));
        model_u.pulse(2, 1);
        bus(1'b1, REG_CTRL, 32'(EPW_BUF_EDGE) | (32'h1 << CF_SAMP_FALL) | (32'h2 << CF_SAMP_SEL));
        model_u.pulse(0, 2);
        model_u.level(2, 1'b1);
        model_u.pulse(0, 1);
        st_q.push_back(32'h3);
        model_u.level(2, 1'b0);
        // Single width armed inside a pulse, later pulses ignored
        n = $urandom_range(2, 6);
        model_u.level(1, 1'b1);
        bus(1'b1, REG_CTRL, 32'(EPW_PW_SINGLE) | (32'h1 << CF_GATE_SEL));
        model_u.pulse(0, 2);
        model_u.level(1, 1'b0);
        st_q.push_back(32'(n));
        model_u.gated(n);
        model_u.gated(1);
        rd(REG_COUNT, 32'(n));
        // Implicit width, one sample per trailing edge
        bus(1'b1, REG_CTRL, 32'(EPW_PW_IMPL) | (32'h1 << CF_GATE_SEL));
        for (int k = 1; k < 4; k++) begin
            st_q.push_back(32'(k));
            model_u.gated(k);
        end
        // Low pulses: armed inside a low level, which is skipped, then one low pulse
        bus(1'b1, REG_CTRL, 32'(EPW_PW_IMPL) | (32'h1 << CF_GATE_LOW) | (32'h1 << CF_GATE_SEL));
        model_u.level(1, 1'b1);
        model_u.level(1, 1'b0);
        model_u.pulse(0, 2);
        st_q.push_back(32'h2);
        model_u.level(1, 1'b1);
        model_u.level(1, 1'b0);
        // Sample-clocked width, second sample with no new pulse overruns
        bus(1'b1, REG_CTRL, 32'(EPW_PW_SAMP) | (32'h1 << CF_GATE_SEL) | (32'h2 << CF_SAMP_SEL));
        model_u.gated(4);
        st_q.push_back(32'h4);
        model_u.pulse(2, 1);
        model_u.pulse(2, 1);
        repeat (30) @(posedge clk);
        rd(REG_STATUS, 32'h9);
        rd(REG_RSVD, 32'h0);
        n = 0;
        while (st_q.size() != 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check(32'(st_q.size()), 32'h0, "pending");
        summarize();
    end
    // Watchdog well beyond the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : epw_counter_top_tb_top
`default_nettype wire
